// File: logic/codec_bridge_pkg.sv
package codec_bridge_pkg;

	// Register byte addresses on the bus
	localparam logic [31:0] CMD_ADDR      = 32'h100200a4;
	localparam logic [31:0] READBACK_ADDR = 32'h100200a8;

	// Reset values
	localparam logic [31:0] CMD_RESET      = 32'h00000000;
	localparam logic [7:0]  CODEC_RESET    = 8'h00;
	localparam logic [31:0] UNMAPPED_VALUE = 32'h00000000;

	// Field layout of the access command register
	localparam int VALUE_LSB = 0;
	localparam int VALUE_W   = 8;
	localparam int INDEX_LSB = 8;
	localparam int INDEX_W   = 7;
	localparam int GO_BIT    = 16;

	// Field layout of the readback register
	localparam int RB_VALUE_LSB = 0;
	localparam int IRQ_BIT      = 8;

	// Bus geometry
	localparam int BUS_W   = 32;
	localparam int LANES   = 4;
	localparam int LANE_W  = 8;
	localparam int WORD_LSB = 2;

	// Write latency budget: longest time, rounded down, at least one cycle
	localparam real WRITE_MAX_US  = 0.17;
	localparam real BUS_CLK_MHZ   = 20.0;
	localparam int  WRITE_FLOOR   = int'($floor(WRITE_MAX_US * BUS_CLK_MHZ));
	localparam int  WRITE_CYCLES  = (WRITE_FLOOR < 1) ? 1 : WRITE_FLOOR;
	localparam int  WRITE_SLACK   = 1;
	localparam int  CNT_W         = 4;

	// Transfer sequencer states
	typedef enum logic [0:0] {
		ST_IDLE,
		ST_BUSY
	} xfer_state_type;

endpackage

// File: logic/codec_reg_file.sv
`timescale 1ns/1ps
module codec_reg_file
	import codec_bridge_pkg::*;
#(
	parameter int          IDX_W   = INDEX_W,
	parameter int          DATA_W  = VALUE_W,
	parameter logic [7:0]  INIT    = CODEC_RESET
)
(
	// Clock and reset
	input  wire logic              i_codec_master_clock,
	input  wire logic              i_rst,
	// Write port
	input  wire logic              i_wr_en,
	input  wire logic [IDX_W-1:0]  i_wr_index,
	input  wire logic [DATA_W-1:0] i_wr_value,
	// Read port
	input  wire logic [IDX_W-1:0]  i_rd_index,
	output logic      [DATA_W-1:0] o_rd_value
);

	localparam int DEPTH = 1 << IDX_W;

	logic [DATA_W-1:0] regs_q [DEPTH];

	// Storage, cleared to its reset value
	always_ff @(posedge i_codec_master_clock)
	begin
		if (i_rst)
		begin
			for (int i = 0; i < DEPTH; i++)
			begin
				regs_q[i] <= DATA_W'(INIT);
			end
		end
		else if (i_wr_en)
		begin
			regs_q[i_wr_index] <= i_wr_value;
		end
	end

	// Live read of the selected entry
	assign o_rd_value = regs_q[i_rd_index];

endmodule // codec_reg_file

// File: logic/codec_register_access_bridge.sv
`timescale 1ns/1ps

module codec_register_access_bridge
	import codec_bridge_pkg::*;
#(
	parameter int IDX_W  = INDEX_W,
	parameter int DATA_W = VALUE_W
)
(
	// Clock and reset
	input  wire logic             i_codec_master_clock,
	input  wire logic             i_rst,
	// Wishbone slave
	input  wire logic             i_wb_cyc,
	input  wire logic             i_wb_stb,
	input  wire logic             i_wb_we,
	input  wire logic [BUS_W-1:0] i_wb_adr,
	input  wire logic [LANES-1:0] i_wb_sel,
	input  wire logic [BUS_W-1:0] i_wb_dat,
	output logic      [BUS_W-1:0] o_wb_dat,
	output logic                  o_wb_ack,
	// Interrupt requests
	input  wire logic             i_audio_irq,
	input  wire logic             i_codec_irq,
	output logic                  o_audio_irq
);

	// Byte-lane merge of write data into a stored word
	function automatic logic [BUS_W-1:0] merge_lanes(
		input logic [BUS_W-1:0] old_word,
		input logic [BUS_W-1:0] new_word,
		input logic [LANES-1:0] sel
	);
		logic [BUS_W-1:0] res;
		res = old_word;
		for (int l = 0; l < LANES; l++)
		begin
			if (sel[l])
			begin
				res[l*LANE_W +: LANE_W] = new_word[l*LANE_W +: LANE_W];
			end
		end
		return res;
	endfunction

	// Word-address match of a bus address
	function automatic logic addr_hit(
		input logic [BUS_W-1:0] adr,
		input logic [BUS_W-1:0] reg_addr
	);
		return adr[BUS_W-1:WORD_LSB] == reg_addr[BUS_W-1:WORD_LSB];
	endfunction

	// Bus handshake state
	logic                  ack_q;
	logic                  ack_d;
	logic [BUS_W-1:0]      rdata_q;
	logic [BUS_W-1:0]      rdata_d;

	// Command register fields
	logic [IDX_W-1:0]      index_q;
	logic [IDX_W-1:0]      index_d;
	logic [DATA_W-1:0]     value_q;
	logic [DATA_W-1:0]     value_d;

	// Transfer sequencer
	xfer_state_type        state_q;
	xfer_state_type        state_d;
	logic [CNT_W-1:0]      cnt_q;
	logic [CNT_W-1:0]      cnt_d;

	// Interrupt synchronisers and shared output
	logic                  codec_irq_meta_q;
	logic                  codec_irq_q;
	logic                  audio_irq_meta_q;
	logic                  audio_irq_q;
	logic                  irq_out_q;

	// Bus decode
	wire logic             bus_req;
	wire logic             hit_cmd;
	wire logic             hit_rb;
	wire logic             commit;
	wire logic             cmd_write;
	wire logic             busy;
	wire logic [BUS_W-1:0] cmd_view;
	wire logic [BUS_W-1:0] rb_view;
	wire logic [BUS_W-1:0] cmd_merged;
	wire logic             go_written;
	wire logic             last_cycle;
	wire logic             codec_wr_en;
	wire logic [DATA_W-1:0] codec_rd_value;

	// Request decode; a write lands on the edge that sees ack high
	assign bus_req   = i_wb_cyc & i_wb_stb;
	assign hit_cmd   = addr_hit(i_wb_adr, CMD_ADDR);
	assign hit_rb    = addr_hit(i_wb_adr, READBACK_ADDR);
	assign commit    = bus_req & ack_q;
	assign cmd_write = commit & i_wb_we & hit_cmd & ~busy;
	assign busy      = (state_q == ST_BUSY);

	assign cmd_view = {
		{(BUS_W-GO_BIT-1){1'b0}},
		busy,
		{(GO_BIT-INDEX_LSB-IDX_W){1'b0}},
		index_q,
		value_q
	};

	// live byte of the selected entry
	assign rb_view = {
		{(BUS_W-IRQ_BIT-1){1'b0}},
		codec_irq_q,
		codec_rd_value
	};

	// Merged command word and go detection
	assign cmd_merged = merge_lanes(cmd_view, i_wb_dat, i_wb_sel);
	assign go_written = cmd_write & cmd_merged[GO_BIT];

	// Last budget cycle of a running transfer
	assign last_cycle  = busy & (cnt_q == CNT_W'(WRITE_CYCLES - 1));
	assign codec_wr_en = last_cycle;

	// Handshake: ack one cycle after the request, dropped the cycle after
	always_comb
	begin
		ack_d   = bus_req & ~ack_q;
		rdata_d = rdata_q;
		if (bus_req & ~ack_q)
		begin
			if (hit_cmd)
			begin
				rdata_d = cmd_view;
			end
			else if (hit_rb)
			begin
				rdata_d = rb_view;
			end
			else
			begin
				rdata_d = UNMAPPED_VALUE;
			end
		end
	end

	// Field loads from the command register
	always_comb
	begin
		index_d = index_q;
		value_d = value_q;
		if (cmd_write)
		begin
			// index field loaded from the bus
			// index feeds the readback at once
			index_d = cmd_merged[INDEX_LSB +: IDX_W];
			// value field loaded from the bus
			value_d = cmd_merged[VALUE_LSB +: DATA_W];
		end
	end

	// Transfer sequencer
	always_comb
	begin
		state_d = state_q;
		cnt_d   = cnt_q;
		unique case (state_q)
			ST_IDLE:
			begin
				cnt_d = '0;
				if (go_written)
				begin
					state_d = ST_BUSY;
				end
			end
			ST_BUSY:
			begin
				// go holds until the store lands
				if (last_cycle)
				begin
					state_d = ST_IDLE;
					cnt_d   = '0;
				end
				else
				begin
					cnt_d = cnt_q + CNT_W'(1);
				end
			end
		endcase
	end

	// Bus side registers
	always_ff @(posedge i_codec_master_clock)
	begin
		if (i_rst)
		begin
			ack_q   <= 1'b0;
			rdata_q <= '0;
		end
		else
		begin
			ack_q   <= ack_d;
			rdata_q <= rdata_d;
		end
	end

	// Command fields and sequencer
	always_ff @(posedge i_codec_master_clock)
	begin
		if (i_rst)
		begin
			index_q <= CMD_RESET[INDEX_LSB +: IDX_W];
			value_q <= CMD_RESET[VALUE_LSB +: DATA_W];
			state_q <= ST_IDLE;
			cnt_q   <= '0;
		end
		else
		begin
			index_q <= index_d;
			value_q <= value_d;
			state_q <= state_d;
			cnt_q   <= cnt_d;
		end
	end

	// Two-stage synchronisers for the interrupt inputs
	always_ff @(posedge i_codec_master_clock)
	begin
		if (i_rst)
		begin
			codec_irq_meta_q <= 1'b0;
			codec_irq_q      <= 1'b0;
			audio_irq_meta_q <= 1'b0;
			audio_irq_q      <= 1'b0;
		end
		else
		begin
			codec_irq_meta_q <= i_codec_irq;
			codec_irq_q      <= codec_irq_meta_q;
			audio_irq_meta_q <= i_audio_irq;
			audio_irq_q      <= audio_irq_meta_q;
		end
	end

	always_ff @(posedge i_codec_master_clock)
	begin
		if (i_rst)
		begin
			irq_out_q <= 1'b0;
		end
		else
		begin
			irq_out_q <= audio_irq_q | codec_irq_q;
		end
	end

	// held index and value, single write pulse
	codec_reg_file #(
		.IDX_W  (IDX_W),
		.DATA_W (DATA_W),
		.INIT   (CODEC_RESET)
	) u_codec_regs (
		.i_codec_master_clock  (i_codec_master_clock),
		.i_rst      (i_rst),
		.i_wr_en    (codec_wr_en),
		.i_wr_index (index_q),
		.i_wr_value (value_q),
		.i_rd_index (index_q),
		.o_rd_value (codec_rd_value)
	);

	// Outputs
	assign o_wb_ack    = ack_q;
	assign o_wb_dat    = rdata_q;
	assign o_audio_irq = irq_out_q;

endmodule // codec_register_access_bridge

// File: bench/bridge_monitor.sv
`timescale 1ns/1ps
module bridge_monitor
	import codec_bridge_pkg::*;
(
	// Clock and reset
	input wire logic             i_codec_master_clock,
	input wire logic             i_rst,
	// Bus and interrupts
	input wire logic             i_wb_cyc,
	input wire logic             i_wb_stb,
	input wire logic             i_wb_we,
	input wire logic [BUS_W-1:0] i_wb_adr,
	input wire logic [LANES-1:0] i_wb_sel,
	input wire logic [BUS_W-1:0] i_wb_dat,
	input wire logic [BUS_W-1:0] o_wb_dat,
	input wire logic             o_wb_ack,
	input wire logic             i_audio_irq,
	input wire logic             i_codec_irq,
	input wire logic             o_audio_irq
);
	default clocking cb @(posedge i_codec_master_clock); endclocking
	default disable iff (i_rst);
	// Address decode of the answered access
	wire        at_cmd = i_wb_adr[31:2] == CMD_ADDR[31:2];
	wire        at_rb  = i_wb_adr[31:2] == READBACK_ADDR[31:2];
	wire        rd_ack = i_wb_cyc && i_wb_stb && !i_wb_we && o_wb_ack;
	wire        go_wr  = i_wb_cyc && i_wb_stb && i_wb_we && o_wb_ack && at_cmd && i_wb_sel[2] && i_wb_dat[GO_BIT];
	logic [3:0] since_go_q;
	logic [3:0] since_go_d;
	// Cycles since the last start request, saturating
	assign since_go_d = go_wr ? 4'h1 : (since_go_q == 4'h0 || since_go_q == 4'hf) ? since_go_q : since_go_q + 4'h1;
	always_ff @(posedge i_codec_master_clock)
	begin
		since_go_q <= i_rst ? 4'h0 : since_go_d;
	end
	a_ack_follows: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack) else $error("no ack");
	a_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack too long");
	a_irq_high: assert property ((i_audio_irq || i_codec_irq) [*4] |=> o_audio_irq) else $error("irq lost");
	a_irq_low: assert property (!(i_audio_irq || i_codec_irq) [*4] |=> !o_audio_irq) else $error("irq stuck");
	a_cmd_reserved: assert property (rd_ack && at_cmd |-> o_wb_dat[31:17] == 15'h0 && !o_wb_dat[15]) else $error("cmd bits");
	a_rb_reserved: assert property (rd_ack && at_rb |-> o_wb_dat[31:9] == 23'h0) else $error("rb bits");
	a_unmapped_zero: assert property (rd_ack && !at_cmd && !at_rb |-> o_wb_dat == UNMAPPED_VALUE) else $error("unmapped");
	a_go_bounded: assert property (rd_ack && at_cmd && o_wb_dat[GO_BIT] |-> since_go_q inside {[1:6]}) else $error("go stuck");
	cover property (go_wr);
	cover property (rd_ack && at_cmd && o_wb_dat[GO_BIT]);
	cover property (o_audio_irq);
endmodule // bridge_monitor

// File: bench/wb_master_model.sv
`timescale 1ns/1ps
module wb_master_model
(
	// Clock
	input  wire logic        i_clk,
	// Bus
	output logic             o_cyc,
	output logic             o_stb,
	output logic             o_we,
	output logic [31:0]      o_adr,
	output logic [3:0]       o_sel,
	output logic [31:0]      o_dat,
	input  wire logic [31:0] i_rdat,
	input  wire logic        i_ack
);
	initial
	begin
		{o_cyc, o_stb, o_we, o_adr, o_sel, o_dat} = '0;
	end
	// One classic cycle, held until ack, then a free cycle
	task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
		o_cyc <= 1'b1;
		o_stb <= 1'b1;
		o_we  <= w;
		o_adr <= a;
		o_sel <= 4'hf;
		o_dat <= w ? d : ~o_dat;
		do @(posedge i_clk); while (i_ack !== 1'b1);
		q = i_rdat;
		o_cyc <= 1'b0;
		o_stb <= 1'b0;
		@(posedge i_clk);
	endtask
endmodule // wb_master_model

// File: bench/tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin bad_count++; \
	$display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
module tb;
	import codec_bridge_pkg::*;
	typedef struct {logic [31:0] cmd; logic [7:0] exp;} row_type;
	logic        clk = 0, rst = 1, cyc, stb, we, ack, aud = 0, cdc = 0, irq;
	logic [31:0] adr, wdat, rdat, q;
	logic [3:0]  sel;
	int          bad_count = 0, n_compared = 0, cycles = 0;
	row_type     rows [5] = '{'{32'h00010a5c, 8'h5c}, '{32'h00000a33, 8'h5c}, '{32'h00017f01, 8'h01},
		'{32'h000100a5, 8'ha5}, '{32'h00000a00, 8'h5c}};
	wb_master_model bfm (.i_clk(clk), .o_cyc(cyc), .o_stb(stb), .o_we(we), .o_adr(adr), .o_sel(sel),
		.o_dat(wdat), .i_rdat(rdat), .i_ack(ack));
	codec_register_access_bridge DUT (.i_codec_master_clock(clk), .i_rst(rst), .i_wb_cyc(cyc), .i_wb_stb(stb),
		.i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
		.i_audio_irq(aud), .i_codec_irq(cdc), .o_audio_irq(irq));
	initial
	begin
		forever #25 clk = ~clk;
	end
	// Hang guard
	always @(posedge clk)
	begin
		cycles++;
		if (cycles > 4000)
		begin
			bad_count++;
			test_done();
		end
	end
	task automatic test_done();
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial
	begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		bfm.xfer(0, CMD_ADDR, 0, q);
		`CHK(q, CMD_RESET)
		bfm.xfer(0, READBACK_ADDR, 0, q);
		`CHK(q, 32'h0)
		// Software order: write, poll once (busy only for rows with go set), once done, then read back
		foreach (rows[i])
		begin
			bfm.xfer(1, CMD_ADDR, rows[i].cmd, q);
			bfm.xfer(0, CMD_ADDR, 0, q);
			`CHK(q[16], rows[i].cmd[16])
			bfm.xfer(0, CMD_ADDR, 0, q);
			`CHK(q, rows[i].cmd & 32'h00007fff)
			bfm.xfer(0, READBACK_ADDR, 0, q);
			`CHK(q, {24'h0, rows[i].exp})
		end
		// Command written while busy is dropped
		bfm.xfer(1, CMD_ADDR, 32'hffffffff, q);
		bfm.xfer(1, CMD_ADDR, 32'h00010a11, q);
		bfm.xfer(0, CMD_ADDR, 0, q);
		`CHK(q, 32'h00007fff)
		bfm.xfer(0, READBACK_ADDR, 0, q);
		`CHK(q, 32'h000000ff)
		bfm.xfer(1, READBACK_ADDR, 32'hffffffff, q);
		bfm.xfer(0, 32'h10020000, 0, q);
		`CHK(q, UNMAPPED_VALUE)
		// Interrupt sources onto the shared line
		cdc <= 1'b1;
		repeat (5) @(posedge clk);
		`CHK(irq, 1'b1)
		bfm.xfer(0, READBACK_ADDR, 0, q);
		`CHK(q, 32'h000001ff)
		cdc <= 1'b0;
		aud <= 1'b1;
		repeat (5) @(posedge clk);
		`CHK(irq, 1'b1)
		bfm.xfer(0, READBACK_ADDR, 0, q);
		`CHK(q[8], 1'b0)
		aud <= 1'b0;
		repeat (5) @(posedge clk);
		`CHK(irq, 1'b0)
		// Reset in mid-transfer clears command, codec bytes and bus outputs
		bfm.xfer(1, CMD_ADDR, 32'h00010a77, q);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		`CHK({ack, irq, rdat}, 34'h0)
		rst <= 1'b0;
		@(posedge clk);
		bfm.xfer(0, CMD_ADDR, 0, q);
		`CHK(q, CMD_RESET)
		bfm.xfer(0, READBACK_ADDR, 0, q);
		`CHK(q, 32'h0)
		test_done();
	end
endmodule // tb
bind codec_register_access_bridge bridge_monitor mon (.i_codec_master_clock(i_codec_master_clock), .i_rst(i_rst), .i_wb_cyc(i_wb_cyc),
	.i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat),
	.o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_audio_irq(i_audio_irq), .i_codec_irq(i_codec_irq),
	.o_audio_irq(o_audio_irq));
